// [logic/mti_defines.svh]
// constants for the terminal interface: field positions, counts, pin slots
`ifndef MTI_DEFINES_SVH
`define MTI_DEFINES_SVH

// received word layout, bits counted from the first received bit
`define MTI_WORD_BITS 16
`define MTI_ADDR_LAST_IDX 5'd4
`define MTI_MODE_IDX 5'd5
`define MTI_SUBADDR_LAST_IDX 5'd10
`define MTI_COUNT_LAST_IDX 5'd15
`define MTI_FIELD_ONES 5'h1F
`define MTI_FIELD_ZERO 5'h00

// message sizes and timing counts in receive clocks
`define MTI_COUNT_ZERO_MEANS 6'd32
`define MTI_CONTROLLER_WORDS 6'd33
`define MTI_IDLE_CLOCKS 6'd32
`define MTI_VALID_WAIT 2'd2

// slots of the synchronised control pin vector
`define MTI_PIN_COUNT 12
`define MTI_P_RXCLK 0
`define MTI_P_CMDSYN 1
`define MTI_P_DATSYN 2
`define MTI_P_RXNRZ 3
`define MTI_P_VALID 4
`define MTI_P_SEND 5
`define MTI_P_TX_BIT_CLOCK 6
`define MTI_P_ACK 7
`define MTI_P_TX_MODE_PULSE 8
`define MTI_P_LOAD 9
`define MTI_P_READ 10
`define MTI_P_ROLE 11

`endif

// [logic/mti_pkg.sv]
// shared types of the terminal interface
`default_nettype none
package mti_pkg;
  // kind of the word currently inside a sync envelope
  typedef enum logic [1:0] {MTI_KIND_NONE, MTI_KIND_CMD, MTI_KIND_DATA}
    mti_kind_t;
endpackage
`default_nettype wire

// [logic/mti_sync_edge.sv]
// two-flop synchroniser with edge detection on the settled level
`default_nettype none
module mti_sync_edge
  import mti_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  // first stage is read only by the second stage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta <= '0;
      level <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= async;
      level <= meta;
      prev <= level;
    end
  end

  // edges compare settled level with its own delayed copy
  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule
`default_nettype wire

// [logic/mti_tx_path.sv]
// transmit holding register, byte pairing and nrz shifter
`default_nettype none
`include "mti_defines.svh"
module mti_tx_path
  import mti_pkg::*;
#(
  parameter int WORD_W = `MTI_WORD_BITS
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sendData,
  input wire logic sendRise,
  input wire logic txClkFall,
  input wire logic loadPulse,
  input wire logic [7:0] loadByte,
  output logic serialTxOut,
  output logic txWordRequest
);
  logic [WORD_W-1:0] hold;
  logic [WORD_W-1:0] shifter;
  logic lowByteNext;
  logic holdFull;

  // first load strobe fills the high byte, second the low byte
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hold <= '0;
      lowByteNext <= 1'b0;
    end
    else if (loadPulse)
    begin
      if (!lowByteNext)
        hold[WORD_W-1 -: 8] <= loadByte;
      else
        hold[7:0] <= loadByte;
      lowByteNext <= ~lowByteNext;
    end
  end

  // hold is consumed at the envelope start; a late second byte still wins
  always_ff @(posedge clk)
  begin
    if (srst)
      holdFull <= 1'b0;
    else if (loadPulse && lowByteNext)
      holdFull <= 1'b1;
    else if (sendRise)
      holdFull <= 1'b0;
  end

  // request more data whenever the holding register is free
  always_ff @(posedge clk)
  begin
    if (srst)
      txWordRequest <= 1'b1;
    else
      txWordRequest <= ~holdFull & ~(loadPulse & lowByteNext);
  end

  // parallel copy while send is low, msb-first shift on clock falls
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shifter <= '0;
      serialTxOut <= 1'b0;
    end
    else if (!sendData)
    begin
      shifter <= hold;
      serialTxOut <= hold[WORD_W-1];
    end
    else if (txClkFall)
    begin
      shifter <= {shifter[WORD_W-2:0], 1'b0};
      serialTxOut <= shifter[WORD_W-2];
    end
  end
endmodule
`default_nettype wire

// [logic/mti_terminal_interface.sv]
// protocol and byte-buffering core between a host byte bus and a codec
`default_nettype none
`include "mti_defines.svh"

module mti_terminal_interface
  import mti_pkg::*;
#(
  parameter int ADDR_W = 5,
  parameter int WORD_W = `MTI_WORD_BITS
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rxBitClock,
  input wire logic commandSyncIn,
  input wire logic dataSyncIn,
  input wire logic serialRxIn,
  input wire logic wordValidIn,
  input wire logic sendDataHandshake,
  input wire logic txBitClock,
  input wire logic interruptAck,
  input wire logic txModePulse,
  input wire logic txByteLoadStrobe,
  input wire logic rxByteReadStrobe,
  input wire logic controllerRoleSelect,
  input wire logic [ADDR_W-1:0] terminalAddressIn,
  input wire logic [7:0] hostByteBusIn,
  output logic [7:0] hostByteBusOut,
  output logic [7:0] hostByteBusOeN,
  output logic zeroMessageFlag,
  output logic zeroWordFlag,
  output logic invalidWordFlag,
  output logic rxWordReady,
  output logic receiveCmdInterruptN,
  output logic transmitCmdInterruptN,
  output logic broadcastFlagN,
  output logic txWordRequest,
  output logic messageDoneN,
  output logic encoderTxEnable,
  output logic serialTxOut
);
  // word count field: zero encodes the maximum
  function automatic logic [5:0] decodeCount(input logic [4:0] field);
    decodeCount = (field == `MTI_FIELD_ZERO) ? `MTI_COUNT_ZERO_MEANS
                                              : {1'b0, field};
  endfunction

  logic [`MTI_PIN_COUNT-1:0] pinLvl;
  logic [`MTI_PIN_COUNT-1:0] pinRise;
  logic [`MTI_PIN_COUNT-1:0] pinFall;
  logic [ADDR_W+7:0] wideLvl;
  logic [ADDR_W-1:0] addrLvl;
  logic [7:0] busLvl;

  // every pin passes two flops before any logic reads it
  mti_sync_edge #(.WIDTH(`MTI_PIN_COUNT)) ctrlSync (
    .clk(clk),
    .srst(srst),
    .async({controllerRoleSelect, rxByteReadStrobe, txByteLoadStrobe,
            txModePulse, interruptAck, txBitClock, sendDataHandshake,
            wordValidIn, serialRxIn, dataSyncIn, commandSyncIn,
            rxBitClock}),
    .level(pinLvl),
    .rise(pinRise),
    .fall(pinFall)
  );

  mti_sync_edge #(.WIDTH(ADDR_W + 8)) wideSync (
    .clk(clk),
    .srst(srst),
    .async({terminalAddressIn, hostByteBusIn}),
    .level(wideLvl),
    .rise(),
    .fall()
  );

  assign addrLvl = wideLvl[ADDR_W+7:8];
  assign busLvl = wideLvl[7:0];

  logic rxRise;
  logic isController;
  logic syncRise;
  logic ackRise;
  logic modeRise;
  logic sendRise;
  logic wordEnd;
  assign rxRise = pinRise[`MTI_P_RXCLK];
  assign isController = ~pinLvl[`MTI_P_ROLE];
  assign syncRise = pinRise[`MTI_P_CMDSYN] | pinRise[`MTI_P_DATSYN];
  assign ackRise = pinRise[`MTI_P_ACK];
  assign modeRise = pinRise[`MTI_P_TX_MODE_PULSE];
  assign sendRise = pinRise[`MTI_P_SEND];
  assign wordEnd = pinFall[`MTI_P_CMDSYN] | pinFall[`MTI_P_DATSYN];

  mti_kind_t kind;
  logic [4:0] bitCount;
  logic [WORD_W-1:0] rxShift;
  logic [WORD_W-1:0] nextShift;
  logic shiftNow;
  assign nextShift = {rxShift[WORD_W-2:0], pinLvl[`MTI_P_RXNRZ]};
  // codec keeps the envelope to sixteen clocks; a longer one is clipped
  assign shiftNow = rxRise && kind != MTI_KIND_NONE
                    && bitCount != 5'(WORD_W);

  // word kind latched at the sync rise, cleared at its fall
  always_ff @(posedge clk)
  begin
    if (srst)
      kind <= MTI_KIND_NONE;
    else if (pinRise[`MTI_P_CMDSYN])
      kind <= MTI_KIND_CMD;
    else if (pinRise[`MTI_P_DATSYN])
      kind <= MTI_KIND_DATA;
    else if (wordEnd)
      kind <= MTI_KIND_NONE;
  end

  // clock and data cross with equal latency, so the sample lines up
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bitCount <= '0;
      rxShift <= '0;
    end
    else if (syncRise)
      bitCount <= '0;
    else if (shiftNow)
    begin
      rxShift <= nextShift;
      bitCount <= bitCount + 5'd1;
    end
  end

  logic cmdBit;
  assign cmdBit = shiftNow && kind == MTI_KIND_CMD;

  logic addrMatch;
  logic cmdTransmit;
  logic cmdForUs;
  logic [5:0] wordCount;

  // command decode as each field completes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      addrMatch <= 1'b0;
      cmdTransmit <= 1'b0;
      cmdForUs <= 1'b0;
      wordCount <= `MTI_COUNT_ZERO_MEANS;
    end
    else if (cmdBit)
    begin
      if (bitCount == `MTI_ADDR_LAST_IDX)
      begin
        addrMatch <= nextShift[4:0] == 5'(addrLvl);
        cmdForUs <= 1'b0;
      end
      if (bitCount == `MTI_MODE_IDX)
      begin
        cmdTransmit <= nextShift[0];
        cmdForUs <= addrMatch;
      end
      if (bitCount == `MTI_COUNT_LAST_IDX)
        wordCount <= decodeCount(nextShift[4:0]);
    end
  end

  logic [5:0] idleCount;
  logic idleHit;
  // idle line: count receive clocks since the last sync rise
  always_ff @(posedge clk)
  begin
    if (srst || syncRise)
      idleCount <= '0;
    else if (rxRise && idleCount != `MTI_IDLE_CLOCKS)
      idleCount <= idleCount + 6'd1;
  end
  assign idleHit = rxRise && idleCount == `MTI_IDLE_CLOCKS - 6'd1;

  logic flagClear;
  assign flagClear = ackRise | idleHit;

  // interrupts and broadcast, active low; a set beats a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      receiveCmdInterruptN <= 1'b1;
      transmitCmdInterruptN <= 1'b1;
      broadcastFlagN <= 1'b1;
    end
    else
    begin
      if (flagClear)
      begin
        receiveCmdInterruptN <= 1'b1;
        transmitCmdInterruptN <= 1'b1;
        broadcastFlagN <= 1'b1;
      end
      if (cmdBit && bitCount == `MTI_ADDR_LAST_IDX
          && nextShift[4:0] == `MTI_FIELD_ONES)
        broadcastFlagN <= 1'b0;
      if (cmdBit && bitCount == `MTI_MODE_IDX && addrMatch)
      begin
        if (nextShift[0])
          transmitCmdInterruptN <= 1'b0;
        else
          receiveCmdInterruptN <= 1'b0;
      end
    end
  end

  // zero fields of the command, cleared with the interrupts
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      zeroMessageFlag <= 1'b0;
      zeroWordFlag <= 1'b0;
    end
    else
    begin
      if (flagClear)
      begin
        zeroMessageFlag <= 1'b0;
        zeroWordFlag <= 1'b0;
      end
      if (cmdBit && bitCount == `MTI_SUBADDR_LAST_IDX
          && nextShift[4:0] == `MTI_FIELD_ZERO)
        zeroMessageFlag <= 1'b1;
      if (cmdBit && bitCount == `MTI_COUNT_LAST_IDX
          && nextShift[4:0] == `MTI_FIELD_ZERO)
        zeroWordFlag <= 1'b1;
    end
  end

  logic [WORD_W-1:0] rxBuffer;
  logic checkWord;
  logic readyWord;
  // which finished words are checked and which are offered to the host
  always_comb
  begin
    checkWord = 1'b0;
    readyWord = 1'b0;
    unique case (kind)
      MTI_KIND_CMD:
      begin
        checkWord = isController | cmdForUs;
        readyWord = isController;
      end
      MTI_KIND_DATA:
      begin
        checkWord = isController | (cmdForUs & ~cmdTransmit);
        readyWord = 1'b1;
      end
      MTI_KIND_NONE:
      begin
        checkWord = 1'b0;
        readyWord = 1'b0;
      end
    endcase
  end

  // receive buffer loads at the sync fall; the host reads it bytewise
  always_ff @(posedge clk)
  begin
    if (srst)
      rxBuffer <= '0;
    else if (wordEnd)
      rxBuffer <= rxShift;
  end

  logic validArmed;
  logic [1:0] validWait;
  // valid word must follow within two receive clocks of the sync fall
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      validArmed <= 1'b0;
      validWait <= '0;
      invalidWordFlag <= 1'b0;
    end
    else if (wordEnd)
    begin
      validArmed <= checkWord;
      validWait <= '0;
    end
    else if (validArmed)
    begin
      if (pinLvl[`MTI_P_VALID])
        validArmed <= 1'b0;
      else if (rxRise && validWait == `MTI_VALID_WAIT - 2'd1)
      begin
        validArmed <= 1'b0;
        invalidWordFlag <= 1'b1;
      end
      else if (rxRise)
        validWait <= validWait + 2'd1;
    end
    else if (syncRise)
      invalidWordFlag <= 1'b0;
  end

  logic readLow;
  // read strobes alternate bytes; the word is gone after the second
  always_ff @(posedge clk)
  begin
    if (srst || wordEnd)
      readLow <= 1'b0;
    else if (pinFall[`MTI_P_READ])
      readLow <= ~readLow;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rxWordReady <= 1'b0;
    else if (wordEnd && readyWord)
      rxWordReady <= 1'b1;
    else if (pinFall[`MTI_P_READ] && readLow)
      rxWordReady <= 1'b0;
  end

  // tri-state bus: all eight enables low only while a read strobe is high
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hostByteBusOut <= 8'hFF;
      hostByteBusOeN <= 8'hFF;
    end
    else
    begin
      hostByteBusOut <= readLow ? rxBuffer[7:0]
                                : rxBuffer[WORD_W-1 -: 8];
      hostByteBusOeN <= {8{~pinLvl[`MTI_P_READ]}};
    end
  end

  logic [5:0] rxDataCount;
  logic [5:0] txSentCount;
  logic [5:0] txTarget;
  logic lastRxData;
  logic lastTx;
  logic txCommanded;
  assign lastRxData = wordEnd && kind == MTI_KIND_DATA && cmdForUs
                      && ~cmdTransmit && rxDataCount + 6'd1 == wordCount;
  assign lastTx = txSentCount + 6'd1 >= txTarget;

  // data words received for the current command
  always_ff @(posedge clk)
  begin
    if (srst || pinRise[`MTI_P_CMDSYN])
      rxDataCount <= '0;
    else if (wordEnd && kind == MTI_KIND_DATA && cmdForUs)
      rxDataCount <= rxDataCount + 6'd1;
  end

  // envelopes sent since transmit enable was last raised
  always_ff @(posedge clk)
  begin
    if (srst || (modeRise && !encoderTxEnable) || lastRxData)
      txSentCount <= '0;
    else if (pinFall[`MTI_P_SEND] && txSentCount != 6'h3F)
      txSentCount <= txSentCount + 6'd1;
  end

  // a transmit interrupt is remembered until a mode pulse answers it
  always_ff @(posedge clk)
  begin
    if (srst || pinRise[`MTI_P_CMDSYN])
      txCommanded <= 1'b0;
    else if (cmdBit && bitCount == `MTI_MODE_IDX && addrMatch)
      txCommanded <= nextShift[0];
    else if (modeRise)
      txCommanded <= 1'b0;
  end

  // encoder transmit enable per role
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      encoderTxEnable <= 1'b0;
      txTarget <= `MTI_CONTROLLER_WORDS;
    end
    else if (isController)
    begin
      txTarget <= `MTI_CONTROLLER_WORDS;
      if (modeRise)
        encoderTxEnable <= ~encoderTxEnable;
    end
    else if (lastRxData)
    begin
      encoderTxEnable <= 1'b1;
      txTarget <= 6'd1;
    end
    else if (modeRise && encoderTxEnable)
      encoderTxEnable <= 1'b0;
    else if (modeRise && txCommanded)
    begin
      encoderTxEnable <= 1'b1;
      txTarget <= wordCount + 6'd1;
    end
    else if (sendRise && encoderTxEnable && lastTx)
      encoderTxEnable <= 1'b0;
  end

  // message done low at the commanded count, released by a new command
  always_ff @(posedge clk)
  begin
    if (srst)
      messageDoneN <= 1'b1;
    else if (lastRxData)
      messageDoneN <= 1'b0;
    // exact count: a terminal drops enable at the last envelope's start
    else if (pinFall[`MTI_P_SEND] && txSentCount + 6'd1 == txTarget)
      messageDoneN <= 1'b0;
    else if (pinRise[`MTI_P_CMDSYN] || ackRise)
      messageDoneN <= 1'b1;
  end

  // load strobes are ignored while an envelope is shifting out
  mti_tx_path #(.WORD_W(WORD_W)) txPath (
    .clk(clk),
    .srst(srst),
    .sendData(pinLvl[`MTI_P_SEND]),
    .sendRise(sendRise),
    .txClkFall(pinFall[`MTI_P_TX_BIT_CLOCK]),
    .loadPulse(pinRise[`MTI_P_LOAD] & ~pinLvl[`MTI_P_SEND]),
    .loadByte(busLvl),
    .serialTxOut(serialTxOut),
    .txWordRequest(txWordRequest)
  );
endmodule
`default_nettype wire

// [verif/mti_terminal_interface_properties.sv]
// port-level assertions for the terminal interface
`default_nettype none
module mti_terminal_interface_properties
  import mti_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rxBitClock,
  input wire logic commandSyncIn,
  input wire logic dataSyncIn,
  input wire logic sendDataHandshake,
  input wire logic interruptAck,
  input wire logic txModePulse,
  input wire logic rxByteReadStrobe,
  input wire logic controllerRoleSelect,
  input wire logic [7:0] hostByteBusOeN,
  input wire logic zeroMessageFlag,
  input wire logic zeroWordFlag,
  input wire logic rxWordReady,
  input wire logic receiveCmdInterruptN,
  input wire logic transmitCmdInterruptN,
  input wire logic broadcastFlagN,
  input wire logic txWordRequest,
  input wire logic messageDoneN,
  input wire logic encoderTxEnable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lastData;
  logic rxClkQ;
  logic [5:0] idleCnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);

  // kind of the latest envelope seen on the raw pins
  always_ff @(posedge clk)
  begin
    if (srst)
      lastData <= 1'b0;
    else if (commandSyncIn || dataSyncIn)
      lastData <= dataSyncIn;
  end

  // rx clock rises since sync dropped; counts past the design's own
  // idle limit so synchroniser delay cannot cause a false alarm
  always_ff @(posedge clk)
  begin
    rxClkQ <= rxBitClock;
    if (srst || commandSyncIn || dataSyncIn)
      idleCnt <= 6'h00;
    else if (rxBitClock && !rxClkQ && idleCnt != 6'h3F)
      idleCnt <= idleCnt + 6'h01;
  end

  sequence readRise;
    $rose(rxByteReadStrobe);
  endsequence
  sequence readIdle;
    !rxByteReadStrobe [*6];
  endsequence
  sequence flagsClear;
    receiveCmdInterruptN && transmitCmdInterruptN && broadcastFlagN &&
      !zeroMessageFlag && !zeroWordFlag;
  endsequence

  bus_drive_a: assert property (
    readRise |-> ##[2:5] hostByteBusOeN == 8'h00)
    else $error("bus not driven during read strobe");
  bus_release_a: assert property (
    readIdle |-> hostByteBusOeN == 8'hFF)
    else $error("bus still driven after read strobe");
  ack_clear_a: assert property (
    $rose(interruptAck) && !commandSyncIn && !dataSyncIn |->
      ##[3:6] flagsClear)
    else $error("acknowledge left a flag set");
  idle_clear_a: assert property (
    idleCnt == 6'h22 |-> ##[0:8] flagsClear)
    else $error("idle line left a flag set");
  bcast_cause_a: assert property (
    $fell(broadcastFlagN) |-> $past(commandSyncIn, 4))
    else $error("broadcast outside a command envelope");
  rx_int_cause_a: assert property (
    $fell(receiveCmdInterruptN) |->
      $past(commandSyncIn, 4) && transmitCmdInterruptN)
    else $error("receive interrupt without command");
  ready_kind_a: assert property (
    $rose(rxWordReady) && controllerRoleSelect |-> lastData)
    else $error("terminal flagged a non-data word ready");
  toggle_on_a: assert property (
    $rose(txModePulse) && !controllerRoleSelect && !encoderTxEnable
      |-> ##[2:5] encoderTxEnable)
    else $error("mode pulse did not set enable");
  toggle_off_a: assert property (
    $rose(txModePulse) && !controllerRoleSelect && encoderTxEnable
      |-> ##[2:5] !encoderTxEnable)
    else $error("mode pulse did not clear enable");
  request_free_a: assert property (
    $rose(sendDataHandshake) |-> ##[2:6] txWordRequest)
    else $error("holding register not freed by send");
  done_release_a: assert property (
    $rose(commandSyncIn) |-> ##[2:6] messageDoneN)
    else $error("message done kept through new command");
endmodule

bind mti_terminal_interface
  mti_terminal_interface_properties i_props (.*);
`default_nettype wire

// [verif/mti_codec_model.sv]
// behavioural manchester codec facing the terminal interface
`default_nettype none
module mti_codec_model
(
  output var logic rxBitClock,
  output var logic commandSyncIn,
  output var logic dataSyncIn,
  output var logic serialRxIn,
  output var logic wordValidIn,
  output var logic sendDataHandshake,
  output var logic txBitClock,
  input wire logic serialTxOut
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 40;

  // clocks stand still between frames
  initial
  begin
    {rxBitClock, commandSyncIn, dataSyncIn, serialRxIn} = 4'h0;
    {wordValidIn, sendDataHandshake, txBitClock} = 3'h0;
  end

  // one rx clock; data only moves while the clock is low
  task automatic rxTick();
    #HALF rxBitClock = 1'b1;
    #HALF rxBitClock = 1'b0;
  endtask

  // one word in its envelope, then the valid-word answer
  task automatic rxWord(input logic isCmd, input logic [15:0] w,
    input logic good);
    commandSyncIn = isCmd;
    dataSyncIn = !isCmd;
    for (int i = 15; i >= 0; i--)
    begin
      serialRxIn = w[i];
      rxTick();
    end
    serialRxIn = !w[0];
    commandSyncIn = 1'b0;
    dataSyncIn = 1'b0;
    #HALF rxBitClock = 1'b1;
    wordValidIn = good;
    #HALF rxBitClock = 1'b0;
    rxTick();
    wordValidIn = 1'b0;
    rxTick();
  endtask

  // free-running rx clock with no sync; the data line wanders
  task automatic idle(input int n);
    repeat (n)
    begin
      serialRxIn = !serialRxIn;
      rxTick();
    end
  endtask

  // one send envelope of sixteen tx clocks, bits taken before each fall
  task automatic txWord(output logic [15:0] w);
    sendDataHandshake = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      #HALF txBitClock = 1'b1;
      w[i] = serialTxOut;
      #HALF txBitClock = 1'b0;
    end
    #HALF sendDataHandshake = 1'b0;
    #HALF;
  endtask
endmodule
`default_nettype wire

// [verif/mti_terminal_interface_tb.sv]
// self-checking bench for the terminal interface
`default_nettype none
module mti_terminal_interface_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, controllerRoleSelect, serialTxOut, encoderTxEnable;
  logic rxBitClock, commandSyncIn, dataSyncIn, serialRxIn, wordValidIn;
  logic sendDataHandshake, txBitClock, interruptAck, txModePulse;
  logic txByteLoadStrobe, rxByteReadStrobe, zeroMessageFlag, zeroWordFlag;
  logic invalidWordFlag, rxWordReady, receiveCmdInterruptN, txWordRequest;
  logic transmitCmdInterruptN, broadcastFlagN, messageDoneN;
  logic [4:0] terminalAddressIn;
  logic [7:0] hostByteBusIn, hostByteBusOut, hostByteBusOeN;
  logic [3:0] hp;
  logic [4:0] fl;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  // host strobes and the flag group as vectors
  assign {rxByteReadStrobe, txByteLoadStrobe, txModePulse, interruptAck} = hp;
  assign fl = {broadcastFlagN, receiveCmdInterruptN, transmitCmdInterruptN,
    zeroMessageFlag, zeroWordFlag};

  mti_terminal_interface i_dut (.*);
  mti_codec_model i_codec (.*);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end

  // hang guard, well above the longest expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp,
    input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // flags a command word should leave: broadcast, interrupts, zero fields
  function automatic logic [4:0] expFlags(input logic [15:0] c);
    logic hit;
    hit = c[15:11] == terminalAddressIn;
    return {c[15:11] != 5'h1F, !(hit && !c[10]), !(hit && c[10]),
      c[9:5] == 5'h00, c[4:0] == 5'h00};
  endfunction

  function automatic int wordCount(input logic [4:0] f);
    return (f == 5'h00) ? 32 : int'(f);
  endfunction

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // pulses are six cycles wide so the synchroniser always sees them
  task automatic strobe(input int k);
    waitc(1);
    hp[k] = 1'b1;
    waitc(6);
    hp[k] = 1'b0;
    waitc(6);
  endtask

  task automatic readWord(output logic [15:0] w);
    for (int b = 1; b >= 0; b--)
    begin
      waitc(1);
      hp[3] = 1'b1;
      waitc(6);
      chk("bus enable", 16'h0000, {8'h00, hostByteBusOeN});
      w[b*8 +: 8] = hostByteBusOut;
      hp[3] = 1'b0;
      waitc(6);
    end
  endtask

  task automatic loadWord(input logic [15:0] w);
    hostByteBusIn = w[15:8];
    strobe(2);
    hostByteBusIn = w[7:0];
    strobe(2);
  endtask

  task automatic doReset(input logic r);
    waitc(1);
    srst = 1'b1;
    controllerRoleSelect = r;
    waitc(10);
    srst = 1'b0;
    waitc(2);
  endtask

  initial
  begin
    logic [15:0] c, w, r;
    int n;
    hp = 4'h0;
    hostByteBusIn = 8'h00;
    srst = 1'b1;
    controllerRoleSelect = 1'b1;
    void'($urandom(84));
    terminalAddressIn = 5'($urandom % 31);
    doReset(1'b1);
    chk("reset state", 16'h00DC, {7'h00, encoderTxEnable, txWordRequest,
      messageDoneN, rxWordReady, fl});
    // terminal commands: own address, broadcast, zero fields, random
    for (int i = 0; i < 8; i++)
    begin
      c = 16'($urandom);
      if (i < 3)
        c[15:10] = {terminalAddressIn, i[0]};
      if (i == 3)
        c[15:11] = 5'h1F;
      if (i == 1)
        c[9:0] = 10'h000;
      i_codec.rxWord(1'b1, c, 1'b1);
      waitc(4);
      chk("command flags", {11'h0, expFlags(c)}, {11'h0, fl});
      chk("terminal ready", 16'h0000, {15'h0000, rxWordReady});
      readWord(r);
      chk("command read", c, r);
      if (i == 0)
        i_codec.idle(40);
      else
        strobe(0);
      chk("flags cleared", 16'h001C, {11'h000, fl});
    end
    // receive message with count field zero, one word left unconfirmed
    c = {terminalAddressIn, 1'b0, 5'h05, 5'h00};
    i_codec.rxWord(1'b1, c, 1'b1);
    strobe(0);
    n = wordCount(c[4:0]);
    for (int i = 1; i <= n; i++)
    begin
      w = 16'($urandom);
      i_codec.rxWord(1'b0, w, i != 3);
      waitc(4);
      chk("data ready", 16'h0001, {15'h0000, rxWordReady});
      chk("invalid", {15'h0, i == 3}, {15'h0, invalidWordFlag});
      chk("done", {15'h0000, i != n}, {15'h0000, messageDoneN});
      readWord(r);
      chk("data read", w, r);
    end
    chk("reply enable", 16'h0001, {15'h0000, encoderTxEnable});
    i_codec.txWord(r);
    chk("reply cleared", 16'h0000, {15'h0000, encoderTxEnable});
    // controller: command word flagged ready and invalid, thirty-three words sent
    doReset(1'b0);
    c = 16'($urandom);
    i_codec.rxWord(1'b1, c, 1'b0);
    waitc(4);
    chk("ctl rdy", 16'h3, {14'h0, rxWordReady, invalidWordFlag});
    readWord(r);
    chk("ctl read", c, r);
    chk("ready dropped", 16'h0000, {15'h0000, rxWordReady});
    strobe(1);
    chk("enable on", 16'h0001, {15'h0000, encoderTxEnable});
    for (int i = 1; i <= 33; i++)
    begin
      w = 16'($urandom);
      loadWord(w);
      chk("request busy", 16'h0000, {15'h0000, txWordRequest});
      i_codec.txWord(r);
      chk("sent word", w, r);
      chk("request free", 16'h0001, {15'h0000, txWordRequest});
      chk("ctl done", {15'h0, i != 33}, {15'h0, messageDoneN});
    end
    strobe(1);
    chk("enable off", 16'h0000, {15'h0000, encoderTxEnable});
    // terminal transmit: reply word plus one data word
    doReset(1'b1);
    c = {terminalAddressIn, 1'b1, 5'h03, 5'h01};
    i_codec.rxWord(1'b1, c, 1'b1);
    waitc(4);
    chk("tx interrupt", 16'h0, {15'h0, transmitCmdInterruptN});
    strobe(1);
    chk("rt enable", 16'h0001, {15'h0000, encoderTxEnable});
    for (int i = 0; i < 2; i++)
    begin
      w = 16'($urandom);
      loadWord(w);
      i_codec.txWord(r);
      chk("rt word", w, r);
    end
    chk("rt enable off", 16'h0000, {15'h0000, encoderTxEnable});
    chk("rt done", 16'h0, {15'h0, messageDoneN});
    summarize();
  end
endmodule
`default_nettype wire
